// File: src/ildm_monitor.sv
// idle line disconnect monitor: setup parsing, free period timer, poll counter
// assumes line events are synchronous one-cycle pulses from the link logic
//
// Local design decisions: the plain strobed port and the register offsets.
module ildm_monitor
  import ildm_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire ildm_line_t LINE,
  input wire logic QUEUE_AT_FETCH,
  output logic FLUSH,
  output logic DISCONNECT,
  output logic IRQ
);
  // parameter byte buffer and setup state
  logic [7:0] pbuf [0:12];
  logic [7:0] pcount;
  logic enabled;
  logic [15:0] timer_set;
  logic [15:0] polls_set;
  logic [15:0] timer;
  logic [15:0] polls;
  logic [31:0] tick_cnt;
  logic [2:0] ctrl;
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] irq_mask;
  logic [7:0] exc0;
  logic [7:0] exc1;
  logic [15:0] check;
  ildm_state_t state;
  ildm_state_t next_state;

  function automatic logic [15:0] pair(input logic [7:0] hi, input logic [7:0] lo);
    pair = {hi, lo};
  endfunction : pair

  // decode of the register port
  wire wr_param = WR && (ADDR == ADDR_PARAM);
  wire wr_cmd = WR && (ADDR == ADDR_CMD);
  wire wr_ctrl = WR && (ADDR == ADDR_CTRL);
  wire wr_irq_st = WR && (ADDR == ADDR_IRQ_ST);
  wire wr_irq_mask = WR && (ADDR == ADDR_IRQ_MASK);
  wire program_reset = wr_ctrl && WDATA[CTRL_PRESET];
  wire data_phase = ctrl[CTRL_DATA_PHASE];
  wire autopoll = ctrl[CTRL_AUTOPOLL];

  // setup command evaluation
  wire [15:0] new_timer = pair(pbuf[9], pbuf[10]);
  wire [15:0] new_polls = pair(pbuf[11], pbuf[12]);
  wire is_basic = (pcount == COUNT_BASIC);
  wire is_full = (pcount == COUNT_FULL);
  wire has_timer = (pcount >= 8'h0B);
  wire timer_zero = has_timer && (new_timer == 16'h0000);
  wire bad_value = (has_timer && (new_timer > VALUE_MAX))
    || (is_full && (new_polls > VALUE_MAX));
  wire bad_pair = has_timer && !timer_zero && (!is_full || new_polls == 16'h0000);
  wire bad_len = !is_basic && !has_timer;
  wire reject = wr_cmd && (bad_value || bad_pair || bad_len);
  wire accept = wr_cmd && !reject;
  wire set_on = accept && is_full && !timer_zero;
  wire set_off = accept && timer_zero;

  // tick prescaler and counting events
  wire tick = (tick_cnt == TICK_LEN - 1);
  wire poll_bad = LINE.poll_done && !LINE.poll_productive && autopoll;
  wire poll_good = LINE.poll_done && LINE.poll_productive;
  wire both_zero = (timer == 16'h0000) && (polls == 16'h0000);

  // disconnect sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (enabled && data_phase) begin
          next_state = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (!enabled || !data_phase) begin
          next_state = ST_IDLE;
        end else if (both_zero) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!LINE.resp_pending) begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (QUEUE_AT_FETCH) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // parameter byte capture; a setup write restarts the byte count
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      pcount <= 8'h00;
      for (int i = 0; i <= 12; i++) begin
        pbuf[i] <= 8'h00;
      end
    end else if (wr_cmd) begin
      pcount <= 8'h00;
    end else if (wr_param && pcount < COUNT_FULL) begin
      pbuf[pcount[3:0]] <= WDATA[7:0];
      pcount <= pcount + 8'h01;
    end
  end

  // enable setting persists until switched off or reset
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      enabled <= 1'b0;
      timer_set <= 16'h0000;
      polls_set <= 16'h0000;
    end else if (program_reset || set_off) begin
      enabled <= 1'b0;
    end else if (set_on) begin
      enabled <= 1'b1;
      timer_set <= new_timer;
      polls_set <= new_polls;
    end
  end

  // prescaler for tenth second steps
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt <= 32'h0000_0000;
    end else if (state != ST_WATCH || tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // free period timer and poll counter
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      timer <= 16'h0000;
      polls <= 16'h0000;
    end else if (state == ST_IDLE) begin
      timer <= timer_set;
      polls <= polls_set;
    end else if (state == ST_WATCH) begin
      if (tick && timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end
      if (poll_good) begin
        polls <= polls_set;
      end else if (poll_bad && polls != 16'h0000) begin
        polls <= polls - 16'h0001;
      end
    end
  end

  // control, status block bytes and outputs
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= 3'b000;
      exc0 <= 8'h00;
      exc1 <= 8'h00;
      check <= 16'h0000;
      FLUSH <= 1'b0;
      DISCONNECT <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {1'b0, WDATA[CTRL_AUTOPOLL:CTRL_DATA_PHASE]};
      end
      if (reject) begin
        check <= CHECK_CODE;
      end else if (accept) begin
        check <= 16'h0000;
      end
      if (state == ST_HOLD && next_state == ST_FLUSH) begin
        exc0 <= 8'h01 << SOFT_BIT;
        exc1 <= SOFT_CODE;
      end
      FLUSH <= (next_state == ST_FLUSH);
      DISCONNECT <= (state == ST_HOLD && next_state == ST_FLUSH);
    end
  end

  // sticky interrupt status, set wins over write-one-to-clear
  wire [IRQ_W-1:0] irq_ev = {accept, reject, state == ST_HOLD && next_state == ST_FLUSH};
  wire [IRQ_W-1:0] irq_clr = wr_irq_st ? WDATA[IRQ_W-1:0] : '0;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_st <= '0;
      irq_mask <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~irq_clr) | irq_ev;
      if (wr_irq_mask) begin
        irq_mask <= WDATA[IRQ_W-1:0];
      end
      IRQ <= |(((irq_st & ~irq_clr) | irq_ev) & irq_mask);
    end
  end

  // read data, one cycle after the read strobe
  wire [31:0] rd_mux =
    (ADDR == ADDR_CTRL) ? {29'h0, ctrl} :
    (ADDR == ADDR_STATUS) ? {21'h0, pcount, enabled, state} :
    (ADDR == ADDR_TIMER) ? {16'h0, timer} :
    (ADDR == ADDR_POLLS) ? {16'h0, polls} :
    (ADDR == ADDR_EXC) ? {16'h0, exc1, exc0} :
    (ADDR == ADDR_IRQ_ST) ? {29'h0, irq_st} :
    (ADDR == ADDR_IRQ_MASK) ? {29'h0, irq_mask} :
    (ADDR == ADDR_CHECK) ? {16'h0, check} : 32'h0000_0000;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= RD ? rd_mux : 32'h0000_0000;
    end
  end

  // checks
  AST_NO_EARLY_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_WATCH && timer != 16'h0000) |=> !DISCONNECT)
    else $error("disconnect while free period running");
  AST_BOTH_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    DISCONNECT |-> (timer == 16'h0000 && polls == 16'h0000))
    else $error("disconnect before both counts ran out");
  AST_RESP_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_HOLD && LINE.resp_pending) |=> !DISCONNECT)
    else $error("disconnect with response outstanding");
  AST_EXC_CODE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    DISCONNECT |-> (exc1 == SOFT_CODE && exc0[SOFT_BIT]))
    else $error("status block bytes wrong after disconnect");
  AST_REJECT_CODE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    reject |=> check == CHECK_CODE)
    else $error("rejected setup without check code");
  AST_BASIC_KEEP: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (wr_cmd && is_basic && !wr_ctrl) |=> $stable(enabled))
    else $error("basic setup changed the enable");
  AST_POLL_DEC: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_WATCH && next_state == ST_WATCH && poll_bad && !poll_good
     && polls != 16'h0000) |=> polls == $past(polls) - 16'h0001)
    else $error("poll counter did not step down");
  AST_POLL_RELOAD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_WATCH && poll_good) |=> polls == polls_set)
    else $error("productive poll did not reload counter");
  AST_ZERO_OFF: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    set_off |=> !enabled)
    else $error("zero free period left the monitor on");

  // contiguous unproductive poll run, kept apart from the poll counter
  logic [15:0] bad_run;
  logic [15:0] run_base;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      bad_run <= 16'h0000;
      run_base <= 16'h0000;
    end else if (state != ST_WATCH || poll_good) begin
      bad_run <= 16'h0000;
      run_base <= polls_set;
    end else if (poll_bad && bad_run != run_base) begin
      bad_run <= bad_run + 16'h0001;
    end
  end

  // counter plus run length equals the loaded count while watching
  AST_RUN_MATCH: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_WATCH) |-> (polls + bad_run == run_base))
    else $error("poll counter out of step with unproductive run");

  // flush stands until the queue head reaches the status fetch
  AST_FLUSH_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_FLUSH && !QUEUE_AT_FETCH) |=> FLUSH)
    else $error("flush dropped before status fetch");

  // flush ends once the status fetch is at the head
  AST_FLUSH_END: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_FLUSH && QUEUE_AT_FETCH) |=> !FLUSH)
    else $error("flush kept after status fetch");

  // disconnect is a single pulse
  AST_DISC_PULSE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    DISCONNECT |=> !DISCONNECT)
    else $error("disconnect longer than one cycle");

  // free period timer only moves on a tick while watching
  AST_TIMER_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_WATCH && !tick) |=> timer == $past(timer))
    else $error("timer moved without a tick");

  // one step down per tick while running
  AST_TIMER_STEP: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_WATCH && tick && timer != 16'h0000) |=> timer == $past(timer) - 16'h0001)
    else $error("timer did not step on a tick");

  // prescaler stays inside one tenth second period
  AST_TICK_RANGE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    tick_cnt < TICK_LEN)
    else $error("prescaler past its period");

  // counts start from the programmed values at data phase
  AST_WATCH_LOAD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_IDLE && next_state == ST_WATCH && !wr_cmd)
    |=> (timer == timer_set && polls == polls_set))
    else $error("counts not loaded at data phase");

  // unproductive polls outside autopoll leave the counter alone
  AST_ONLY_AUTOPOLL: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_WATCH && LINE.poll_done && !LINE.poll_productive && !autopoll)
    |=> polls == $past(polls))
    else $error("poll outside autopoll was counted");

  // outstanding response keeps the line up
  AST_HOLD_WAIT: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state == ST_HOLD && LINE.resp_pending) |=> state == ST_HOLD)
    else $error("left hold with response outstanding");

  // program reset switches the monitor off
  AST_OFF_RESET: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    program_reset |=> !enabled)
    else $error("program reset left the monitor on");

  // disconnect status bit stays until written with a one
  AST_IRQ_STICKY: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (irq_st[IRQ_DISC] && !(wr_irq_st && WDATA[IRQ_DISC])) |=> irq_st[IRQ_DISC])
    else $error("sticky status bit lost");

  // read data is zero outside the cycle after a read
  AST_RDATA_IDLE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !RD |=> RDATA == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule : ildm_monitor

// File: src/ildm_pkg.sv
// constants and carrier types for the idle line disconnect monitor
// assumes a single 10 MHz system clock and a simple strobe register port
// Notes on behaviour
// - bytes 9-10 timer, 11-12 poll count
// - timer counts tenths of a second
// - timer starts at data phase; no clear
// - only unproductive autopoll polls count
// - each contiguous unproductive poll decrements counter
// - clear only when timer and counter zero
// - hold disconnect while network response outstanding
// - flush command queue up to status fetch
// - status block: soft error, code 40
// - nine byte setup valid, setting unchanged
// - zero timer disables, poll count only range checked
// - enabled until turned off or reset
package ildm_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] COUNT_FULL = 8'h0D;
  localparam logic [7:0] COUNT_BASIC = 8'h09;
  localparam logic [15:0] VALUE_MAX = 16'h7FFF;
  localparam logic [15:0] CHECK_CODE = 16'h0899;
  localparam logic [7:0] SOFT_CODE = 8'h40;
  localparam int unsigned SOFT_BIT = 0;
  // register indices
  localparam logic [3:0] ADDR_PARAM = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_TIMER = 4'h4;
  localparam logic [3:0] ADDR_POLLS = 4'h5;
  localparam logic [3:0] ADDR_EXC = 4'h6;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h7;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] ADDR_CHECK = 4'h9;
  // interrupt bit positions
  localparam int unsigned IRQ_DISC = 0;
  localparam int unsigned IRQ_REJECT = 1;
  localparam int unsigned IRQ_ACCEPT = 2;
  localparam int unsigned IRQ_W = 3;
  // control register bits
  localparam int unsigned CTRL_DATA_PHASE = 0;
  localparam int unsigned CTRL_AUTOPOLL = 1;
  localparam int unsigned CTRL_PRESET = 2;
  typedef struct packed {
    logic poll_done;
    logic poll_productive;
    logic resp_pending;
  } ildm_line_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WATCH = 2'b01,
    ST_HOLD = 2'b10,
    ST_FLUSH = 2'b11
  } ildm_state_t;
endpackage : ildm_pkg

// File: testbench/ildm_dce_model.sv
// line side model: poll results, link responses, command queue head
// assumes the bench pulses go for one cycle per poll request
module ildm_dce_model
  import ildm_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic go,
  input wire logic good,
  input wire logic hold,
  input wire logic FLUSH,
  output ildm_line_t LINE,
  output logic QUEUE_AT_FETCH
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  // poll ends a cycle after the request; idle qualifier keeps toggling
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      LINE <= '0;
      wait_cnt <= 2'h0;
      QUEUE_AT_FETCH <= 1'b0;
    end else begin
      LINE.poll_done <= go;
      LINE.poll_productive <= go ? good : ~LINE.poll_productive;
      LINE.resp_pending <= hold;
      wait_cnt <= FLUSH ? wait_cnt + 2'h1 : 2'h0;
      QUEUE_AT_FETCH <= FLUSH && (wait_cnt == 2'h3);
    end
  end
endmodule : ildm_dce_model

// File: testbench/tb_top.sv
// self-checking bench for the idle line disconnect monitor
// assumes a short tick of 10 cycles and the line side model
module tb_top
  import ildm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 1'b0;
  logic RESET_N = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic go = 1'b0;
  logic good = 1'b0;
  logic hold = 1'b0;
  logic [31:0] RDATA;
  ildm_line_t LINE;
  logic QUEUE_AT_FETCH;
  logic FLUSH;
  logic DISCONNECT;
  logic IRQ;
  logic irq_a;
  logic [31:0] v;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int disc_n = 0;
  int flush_n = 0;
  ildm_monitor #(.TICK_LEN(10)) dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINE(LINE),
    .QUEUE_AT_FETCH(QUEUE_AT_FETCH), .FLUSH(FLUSH), .DISCONNECT(DISCONNECT), .IRQ(IRQ));
  ildm_dce_model dce (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .go(go), .good(good),
    .hold(hold), .FLUSH(FLUSH), .LINE(LINE), .QUEUE_AT_FETCH(QUEUE_AT_FETCH));
  always #50 CLK_SYS = ~CLK_SYS;
  // pulse counters and hang guard
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (DISCONNECT === 1'b1) disc_n <= disc_n + 1;
    if (FLUSH === 1'b1) flush_n <= flush_n + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    v = RDATA;
  endtask : rd
  // bytes 9..12 carry timer and poll count, high byte first
  task automatic setup(input int n, input logic [15:0] t, input logic [15:0] p);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = (i == 9) ? t[15:8] : (i == 10) ? t[7:0] : (i == 11) ? p[15:8] : 8'h00;
      if (i == 12) b = p[7:0];
      wr(ADDR_PARAM, {24'h000000, b});
    end
    wr(ADDR_CMD, 32'h0);
    repeat (2) @(posedge CLK_SYS);
  endtask : setup
  task automatic poll(input int k, input logic g);
    for (int i = 0; i < k; i++) begin
      @(posedge CLK_SYS);
      go <= 1'b1;
      good <= g;
      @(posedge CLK_SYS);
      go <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
    end
  endtask : poll
  task automatic t_reject();
    setup(13, 16'h0005, 16'h0000);
    rd(ADDR_CHECK);
    chk("check zero polls", v, {16'h0000, CHECK_CODE});
    rd(ADDR_STATUS);
    chk("enabled", v & 32'h4, 32'h0);
    setup(13, 16'h8000, 16'h0001);
    rd(ADDR_CHECK);
    chk("check big timer", v, {16'h0000, CHECK_CODE});
    rd(4'hF);
    chk("unmapped", v, 32'h0);
    $display("test reject done");
  endtask : t_reject
  task automatic t_accept();
    setup(13, 16'h0008, 16'h0003);
    rd(ADDR_CHECK);
    chk("check ok", v, 32'h0);
    rd(ADDR_TIMER);
    chk("timer", v, 32'h8);
    rd(ADDR_POLLS);
    chk("polls", v, 32'h3);
    setup(9, 16'h0000, 16'h0000);
    rd(ADDR_STATUS);
    chk("enabled basic", v & 32'h4, 32'h4);
    rd(ADDR_TIMER);
    chk("timer basic", v, 32'h8);
    $display("test accept done");
  endtask : t_accept
  task automatic t_irq();
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge CLK_SYS);
    irq_a = IRQ;
    wr(ADDR_IRQ_MASK, 32'h7);
    repeat (3) @(posedge CLK_SYS);
    chk("irq masked", {31'h0, irq_a}, 32'h0);
    chk("irq mask", {31'h0, IRQ}, 32'h1);
    wr(ADDR_IRQ_ST, 32'h7);
    repeat (3) @(posedge CLK_SYS);
    chk("irq low", {31'h0, IRQ}, 32'h0);
    rd(ADDR_IRQ_ST);
    chk("irq status", v, 32'h0);
    $display("test irq done");
  endtask : t_irq
  task automatic t_disc();
    hold <= 1'b1;
    wr(ADDR_CTRL, 32'h3);
    poll(2, 1'b0);
    poll(1, 1'b1);
    rd(ADDR_POLLS);
    chk("polls reload", v, 32'h3);
    poll(3, 1'b0);
    rd(ADDR_POLLS);
    chk("polls run out", v, 32'h0);
    chk("no clear early", disc_n, 0);
    repeat (120) @(posedge CLK_SYS);
    rd(ADDR_TIMER);
    chk("timer out", v, 32'h0);
    chk("held", disc_n, 0);
    rd(ADDR_STATUS);
    chk("state", v & 32'h3, {30'h0, ST_HOLD});
    hold <= 1'b0;
    repeat (12) @(posedge CLK_SYS);
    chk("clear", disc_n, 1);
    chk("flush end", {31'h0, FLUSH}, 32'h0);
    chk("flush run", {31'h0, flush_n >= 3}, 32'h1);
    rd(ADDR_EXC);
    chk("exceptions", v, {16'h0000, SOFT_CODE, 8'h01});
    rd(ADDR_IRQ_ST);
    chk("irq disc", v & 32'h1, 32'h1);
    rd(ADDR_STATUS);
    chk("still on", v & 32'h4, 32'h4);
    setup(11, 16'h0000, 16'h0000);
    rd(ADDR_STATUS);
    chk("off", v & 32'h4, 32'h0);
    $display("test disconnect done");
  endtask : t_disc
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    t_reject();
    t_accept();
    t_irq();
    t_disc();
    complete_run();
  end
endmodule : tb_top
